// ---- adsc_map.vh ----
`ifndef ADSC_MAP_VH
`define ADSC_MAP_VH
// ----------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------
`define ADSC_OP_WAKE      8'h02
`define ADSC_OP_SLEEP     8'h04
`define ADSC_OP_RESET     8'h06
`define ADSC_OP_START     8'h08
`define ADSC_OP_STOP      8'h0A
`define ADSC_OP_CONT_ON   8'h10
`define ADSC_OP_CONT_OFF  8'h11
`define ADSC_OP_RDATA     8'h12
// ----------------------------------------------------------------
// Register access prefixes in bits 7..5
// ----------------------------------------------------------------
`define ADSC_PFX_HI       7
`define ADSC_PFX_LO       5
`define ADSC_PFX_READ     3'h1
`define ADSC_PFX_WRITE    3'h2
`define ADSC_PFX_COUNT    3'h0
`define ADSC_FLD_HI       4
`define ADSC_FLD_LO       0
// ----------------------------------------------------------------
// Falling edge indices within a byte (counted from zero)
// ----------------------------------------------------------------
`define ADSC_EDGE_SEVENTH 3'h6
`define ADSC_EDGE_EIGHTH  3'h7
// ----------------------------------------------------------------
// Timing in master clock cycles (the clk cycle)
// ----------------------------------------------------------------
`define ADSC_DECODE_TCLK  4
`define ADSC_RESET_TCLK   18
`define ADSC_DECODE_CYC   3'h4
`define ADSC_RESET_CYC    5'h12
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADSC_RST_CONT     1'b1
`define ADSC_RST_RUN      1'b0
`define ADSC_RST_SLEEP    1'b0
`endif

// ---- adsc_sync2.v ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Two flop synchroniser for one pin level
// ----------------------------------------------------------------
module adsc_sync2 #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk,
  input  wire arst_n,
  input  wire d_in,
  output wire q_out
);

  reg meta_ff; // First stage, read only by the second
  reg sync_ff; // Second stage, safe to use

  // Both stages reset to a constant
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;

endmodule // adsc_sync2

// ---- adsc_cmd_decoder.v ----
`timescale 1ns/1ns
`include "adsc_map.vh"
module adsc_cmd_decoder (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       cs_n,
  input  wire       sclk,
  input  wire       din,
  output wire       dout_o,
  output wire       dout_oe,
  input  wire [7:0] tx_byte,
  input  wire [7:0] reg_rdata,
  output wire       byte_req,
  output wire       reg_rd,
  output wire       reg_wr,
  output wire [4:0] reg_addr,
  output wire [7:0] reg_wdata,
  output wire       pwr_down,
  output wire       conv_run,
  output wire       cont_read,
  output wire       data_read,
  output wire       filt_restart,
  output wire       cfg_reset,
  output wire       reset_busy,
  output wire       cmd_busy
);

  // ----------------------------------------------------------------
  // Byte level states
  // ----------------------------------------------------------------
  localparam ST_CMD  = 3'h0; // Expecting an opcode
  localparam ST_CNT  = 3'h1; // Expecting the count byte
  localparam ST_WR   = 3'h2; // Register write data
  localparam ST_RD   = 3'h3; // Register read data out
  localparam ST_SKIP = 3'h4; // Ignore until chip select rises

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire cs_s;   // Synchronised chip select
  wire sclk_s; // Synchronised serial clock
  wire din_s;  // Synchronised serial input

  adsc_sync2 #(.RST_VAL(1'b1)) u_sync_cs (
    .clk    (clk),
    .arst_n (arst_n),
    .d_in   (cs_n),
    .q_out  (cs_s)
  );

  adsc_sync2 #(.RST_VAL(1'b0)) u_sync_sclk (
    .clk    (clk),
    .arst_n (arst_n),
    .d_in   (sclk),
    .q_out  (sclk_s)
  );

  adsc_sync2 #(.RST_VAL(1'b0)) u_sync_din (
    .clk    (clk),
    .arst_n (arst_n),
    .d_in   (din),
    .q_out  (din_s)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg       sclk_d_ff;  // Delayed clock for edge finding
  reg       cs_d_ff;    // Delayed select for edge finding
  reg [2:0] bit_cnt_ff; // Falling edges seen in this byte
  reg [7:0] rx_ff;      // Input shift register
  reg [7:0] tx_ff;      // Output shift register
  reg       dout_ff;    // Serial output bit
  reg [2:0] state_ff;   // Byte level state
  reg       is_rd_ff;   // Register command is a read
  reg [4:0] addr_ff;    // Current register address
  reg [4:0] rem_ff;     // Registers left minus one
  reg [7:0] wdata_ff;   // Write data
  reg       wr_ff;      // Write strobe
  reg       rd_ff;      // Read strobe
  reg       load_ff;    // Reload output shifter this cycle
  reg       ld_reg_ff;  // Reload from register data
  reg       sleep_ff;   // Low power state
  reg       run_ff;     // Conversions enabled
  reg       cont_ff;    // Continuous readout mode
  reg       dread_ff;   // On-demand read pulse
  reg       frst_ff;    // Filter restart pulse
  reg       cfgr_ff;    // Configuration default pulse
  reg [4:0] rst_cnt_ff; // Reset execution counter
  reg [2:0] gap_cnt_ff; // Byte decode counter

  // ----------------------------------------------------------------
  // Edge and decode terms
  // ----------------------------------------------------------------
  wire       cs_act  = ~cs_s;                       // Interface selected
  wire       fall    = cs_act & sclk_d_ff & ~sclk_s; // Falling SCLK
  wire       rise    = cs_act & ~sclk_d_ff & sclk_s; // Rising SCLK
  wire       cs_fall = cs_d_ff & ~cs_s;             // Frame start
  wire [7:0] nxt_rx  = {rx_ff[6:0], din_s};         // Byte after this bit
  wire       rst_bsy = (rst_cnt_ff != 5'h00);       // Reset executing
  // Bytes arriving during reset execution are dropped
  wire       e7 = fall & ~rst_bsy & (bit_cnt_ff == `ADSC_EDGE_SEVENTH);
  wire       e8 = fall & (bit_cnt_ff == `ADSC_EDGE_EIGHTH);
  wire       e8_ok = e8 & ~rst_bsy;
  wire [6:0] op7  = nxt_rx[6:0]; // First seven bits at seventh edge
  wire [2:0] pfx  = nxt_rx[`ADSC_PFX_HI:`ADSC_PFX_LO];
  wire [4:0] fld  = nxt_rx[`ADSC_FLD_HI:`ADSC_FLD_LO];
  wire       in_cmd = (state_ff == ST_CMD);

  // Seventh-edge opcode matches on the upper seven bits
  wire op_wake  = e7 & in_cmd & ({op7, 1'b0} == (`ADSC_OP_WAKE & 8'hFE));
  wire op_sleep = e7 & in_cmd & ({op7, 1'b0} == (`ADSC_OP_SLEEP & 8'hFE));
  wire op_reset = e7 & in_cmd & ({op7, 1'b0} == (`ADSC_OP_RESET & 8'hFE));
  wire op_start = e7 & in_cmd & ({op7, 1'b0} == (`ADSC_OP_START & 8'hFE));
  wire op_stop  = e7 & in_cmd & ({op7, 1'b0} == (`ADSC_OP_STOP & 8'hFE));
  wire op_rdata = e7 & in_cmd & ({op7, 1'b0} == (`ADSC_OP_RDATA & 8'hFE));
  // 10h and 11h share seven bits, so they need the eighth edge
  wire op_con   = e8_ok & in_cmd & (nxt_rx == `ADSC_OP_CONT_ON);
  wire op_coff  = e8_ok & in_cmd & (nxt_rx == `ADSC_OP_CONT_OFF);

  // ----------------------------------------------------------------
  // Serial shifting, bit count and output reload
  // ----------------------------------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_d_ff  <= 1'b0;
      cs_d_ff    <= 1'b1;
      bit_cnt_ff <= 3'h0;
      rx_ff      <= 8'h00;
      tx_ff      <= 8'h00;
      dout_ff    <= 1'b0;
    end
    else
    begin
      sclk_d_ff <= sclk_s;
      cs_d_ff   <= cs_s;
      if (!cs_act)
      begin
        // Deselect clears only the bit count and the input shift register
        bit_cnt_ff <= 3'h0;
        rx_ff      <= 8'h00;
      end
      else if (fall)
      begin
        rx_ff      <= nxt_rx;
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
      if (load_ff)
      begin
        // Register data or user byte, sampled in the strobe cycle
        tx_ff <= ld_reg_ff ? reg_rdata : tx_byte;
      end
      else if (rise)
      begin
        dout_ff <= tx_ff[7];
        tx_ff   <= {tx_ff[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte level sequencing for register access
  // ----------------------------------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff  <= ST_CMD;
      is_rd_ff  <= 1'b0;
      addr_ff   <= 5'h00;
      rem_ff    <= 5'h00;
      wdata_ff  <= 8'h00;
      wr_ff     <= 1'b0;
      rd_ff     <= 1'b0;
      load_ff   <= 1'b0;
      ld_reg_ff <= 1'b0;
    end
    else
    begin
      wr_ff     <= 1'b0;
      rd_ff     <= 1'b0;
      load_ff   <= cs_fall | (e8 & cs_act);
      ld_reg_ff <= 1'b0;
      // Address advances after each write strobe
      if (wr_ff)
      begin
        addr_ff <= addr_ff + 5'h01;
      end
      if (!cs_act)
      begin
        state_ff <= ST_CMD;
      end
      else if (e8_ok)
      begin
        case (state_ff)
          ST_CMD:
          begin
            // Sleeping accepts nothing but wake
            if (!sleep_ff && pfx == `ADSC_PFX_READ)
            begin
              state_ff <= cont_ff ? ST_SKIP : ST_CNT;
              is_rd_ff <= 1'b1;
              addr_ff  <= fld;
            end
            else if (!sleep_ff && pfx == `ADSC_PFX_WRITE)
            begin
              state_ff <= ST_CNT;
              is_rd_ff <= 1'b0;
              addr_ff  <= fld;
            end
          end
          ST_CNT:
          begin
            if (pfx == `ADSC_PFX_COUNT)
            begin
              rem_ff   <= fld;
              state_ff <= is_rd_ff ? ST_RD : ST_WR;
              rd_ff    <= is_rd_ff;
              ld_reg_ff <= is_rd_ff;
            end
            else
            begin
              // Malformed count byte drops the command
              state_ff <= ST_SKIP;
            end
          end
          ST_WR:
          begin
            wr_ff    <= 1'b1;
            wdata_ff <= nxt_rx;
            rem_ff   <= rem_ff - 5'h01;
            if (rem_ff == 5'h00)
            begin
              state_ff <= ST_CMD;
            end
          end
          ST_RD:
          begin
            if (rem_ff == 5'h00)
            begin
              state_ff <= ST_CMD;
            end
            else
            begin
              rem_ff    <= rem_ff - 5'h01;
              addr_ff   <= addr_ff + 5'h01;
              rd_ff     <= 1'b1;
              ld_reg_ff <= 1'b1;
            end
          end
          ST_SKIP:
          begin
            state_ff <= ST_SKIP;
          end
          default:
          begin
            state_ff <= ST_CMD;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode flags and command effects
  // ----------------------------------------------------------------
  // Chip select plays no part here, so conversions survive deselect
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sleep_ff   <= `ADSC_RST_SLEEP;
      run_ff     <= `ADSC_RST_RUN;
      cont_ff    <= `ADSC_RST_CONT;
      dread_ff   <= 1'b0;
      frst_ff    <= 1'b0;
      cfgr_ff    <= 1'b0;
      rst_cnt_ff <= 5'h00;
      gap_cnt_ff <= 3'h0;
    end
    else
    begin
      dread_ff <= 1'b0;
      frst_ff  <= 1'b0;
      cfgr_ff  <= 1'b0;
      // Every completed byte occupies the decoder four cycles
      if (e8)
      begin
        gap_cnt_ff <= `ADSC_DECODE_CYC;
      end
      else if (gap_cnt_ff != 3'h0)
      begin
        gap_cnt_ff <= gap_cnt_ff - 3'h1;
      end
      if (rst_bsy)
      begin
        rst_cnt_ff <= rst_cnt_ff - 5'h01;
      end
      if (op_wake)
      begin
        sleep_ff <= 1'b0;
      end
      else if (!sleep_ff)
      begin
        // Only wake is honoured while asleep
        if (op_sleep)
        begin
          sleep_ff <= 1'b1;
        end
        if (op_reset)
        begin
          frst_ff    <= 1'b1;
          cfgr_ff    <= 1'b1;
          cont_ff    <= `ADSC_RST_CONT;
          rst_cnt_ff <= `ADSC_RESET_CYC;
        end
        if (op_start && !run_ff)
        begin
          // A start while running changes nothing
          run_ff  <= 1'b1;
          frst_ff <= 1'b1;
        end
        if (op_stop)
        begin
          // Converter finishes its current sample on this level
          run_ff <= 1'b0;
        end
        if (op_rdata)
        begin
          dread_ff <= 1'b1;
        end
        if (op_con)
        begin
          cont_ff <= 1'b1;
        end
        if (op_coff)
        begin
          cont_ff <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dout_o       = dout_ff;
  assign dout_oe      = cs_act;
  assign byte_req     = load_ff & ~ld_reg_ff;
  assign reg_rd       = rd_ff;
  assign reg_wr       = wr_ff;
  assign reg_addr     = addr_ff;
  assign reg_wdata    = wdata_ff;
  assign pwr_down     = sleep_ff;
  assign conv_run     = run_ff;
  assign cont_read    = cont_ff;
  assign data_read    = dread_ff;
  assign filt_restart = frst_ff;
  assign cfg_reset    = cfgr_ff;
  assign reset_busy   = rst_bsy;
  assign cmd_busy     = (gap_cnt_ff != 3'h0);

endmodule // adsc_cmd_decoder

// ---- adsc_cmd_decoder_asserts.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Port checker for the command decoder
// ----------------------------------------
module adsc_cmd_decoder_asserts (
  input wire       clk,
  input wire       arst_n,
  input wire       cs_n,
  input wire       sclk,
  input wire       din,
  input wire       dout_o,
  input wire       dout_oe,
  input wire [7:0] tx_byte,
  input wire [7:0] reg_rdata,
  input wire       byte_req,
  input wire       reg_rd,
  input wire       reg_wr,
  input wire [4:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       pwr_down,
  input wire       conv_run,
  input wire       cont_read,
  input wire       data_read,
  input wire       filt_restart,
  input wire       cfg_reset,
  input wire       reset_busy,
  input wire       cmd_busy
);
  reg  [4:0] rb_len_ff;                                        // Cycles reset_busy stood high
  reg  [4:0] cb_len_ff;                                        // Cycles cmd_busy stood high
  wire [4:0] nxt_rb_len = reset_busy ? rb_len_ff + 5'h01 : 5'h00;
  wire [4:0] nxt_cb_len = cmd_busy ? cb_len_ff + 5'h01 : 5'h00;
  // Window lengths; five bits suffice since both windows are short
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rb_len_ff <= 5'h00;
      cb_len_ff <= 5'h00;
    end
    else
    begin
      rb_len_ff <= nxt_rb_len;
      cb_len_ff <= nxt_cb_len;
    end
  end
  default clocking chk_cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Four samples cover both synchroniser flops; dout_oe is decoded from the second
  sequence s_cs_high; cs_n [*4]; endsequence
  sequence s_cs_low; !cs_n [*4]; endsequence
  a_oe_off_idle: assert property (s_cs_high |-> !dout_oe)
    else $error("output driven while deselected");
  a_oe_on_sel: assert property (s_cs_low |-> dout_oe)
    else $error("output not driven while selected");
  a_reset_len_18: assert property ($fell(reset_busy) |-> rb_len_ff == 5'h12)
    else $error("reset window length wrong");
  a_decode_len_4: assert property ($fell(cmd_busy) |-> cb_len_ff == 5'h04)
    else $error("byte decode window length wrong");
  a_cfg_cont_on: assert property (cfg_reset |-> ##[0:20] cont_read)
    else $error("reset did not restore continuous mode");
  a_sleep_hold: assert property (pwr_down && $past(pwr_down) |-> $stable(conv_run) && $stable(cont_read))
    else $error("state changed while asleep");
  a_wr_addr_step: assert property (reg_wr |=> reg_addr == $past(reg_addr) + 5'h01)
    else $error("write address did not advance");
  a_rd_not_cont: assert property (reg_rd |-> !cont_read)
    else $error("register read in continuous mode");
  // Two sync flops plus the reload flop put the request three samples on
  a_req_on_sel: assert property ($fell(cs_n) |-> ##[2:4] byte_req)
    else $error("output shifter not reloaded at frame start");
endmodule // adsc_cmd_decoder_asserts

bind adsc_cmd_decoder adsc_cmd_decoder_asserts i_chk (.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk),
  .din(din), .dout_o(dout_o), .dout_oe(dout_oe), .tx_byte(tx_byte), .reg_rdata(reg_rdata), .byte_req(byte_req),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .pwr_down(pwr_down),
  .conv_run(conv_run), .cont_read(cont_read), .data_read(data_read), .filt_restart(filt_restart),
  .cfg_reset(cfg_reset), .reset_busy(reset_busy), .cmd_busy(cmd_busy));

// ---- adsc_spi_host.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Serial host model, link period 8 clk
// ----------------------------------------
module adsc_spi_host (
  input  wire clk,
  input  wire miso,
  output reg  cs_n,
  output reg  sclk,
  output reg  din
);
  // No start pin here: conversions are run by command alone, pin low
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end
  // Select or release with margin on both sides of the pin change
  task sel(input on);
  begin
    repeat (8) @(negedge clk);
    cs_n = ~on;
    repeat (8) @(negedge clk);
  end
  endtask
  // Shift nb bits MSB first; reply is taken two clk after each fall,
  // clear of the rise update and of any reload at the byte end
  task xfer(input [7:0] tx, input integer nb, output [7:0] rx);
    integer b;
  begin
    rx = 8'h00;
    for (b = 7; b > 7 - nb; b = b - 1)
    begin
      din  = tx[b];
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
      repeat (2) @(negedge clk);
      rx[b] = miso;
      repeat (2) @(negedge clk);
    end
    repeat (8) @(negedge clk);
  end
  endtask
endmodule // adsc_spi_host

// ---- adsc_cmd_decoder_tb_top.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked = checked + 1; if ((g) !== (e)) begin n_mismatch = n_mismatch + 1; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module adsc_cmd_decoder_tb_top;
  // ----------------------------------------
  // Wiring and user side stimulus
  // ----------------------------------------
  reg        clk = 1'b0;
  reg        arst_n = 1'b0;
  reg        noise = 1'b0;                          // Released line toggles, never holds
  reg  [7:0] tx_byte = 8'h00;
  reg  [7:0] rd_key = 8'h00;                        // Scrambles register read data
  wire       cs_n, sclk, din, dout_o, dout_oe, byte_req, reg_rd, reg_wr;
  wire       pwr_down, conv_run, cont_read, data_read, filt_restart, cfg_reset, reset_busy, cmd_busy;
  wire [4:0] reg_addr;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata = rd_key ^ {3'h0, reg_addr};
  wire       miso = dout_oe ? dout_o : noise;
  integer    seed = 46208;
  integer    n_mismatch = 0, checked = 0, n_fr = 0, n_cfg = 0, n_dr = 0, n_rd = 0, n_wr = 0, i, k, base;
  reg  [7:0] rx, op, wd [0:7], wr_d [0:63];
  reg  [4:0] a, n, wr_a [0:63];
  always #10 clk = ~clk;
  always @(posedge clk) noise <= ~noise;
  // Count pulses and log every register write
  always @(posedge clk)
  begin
    if (filt_restart) n_fr <= n_fr + 1;
    if (cfg_reset) n_cfg <= n_cfg + 1;
    if (data_read) n_dr <= n_dr + 1;
    if (reg_rd) n_rd <= n_rd + 1;
    if (reg_wr)
    begin
      wr_a[n_wr] <= reg_addr;
      wr_d[n_wr] <= reg_wdata;
      n_wr <= n_wr + 1;
    end
  end
  adsc_cmd_decoder i_dut (.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(dout_o),
    .dout_oe(dout_oe), .tx_byte(tx_byte), .reg_rdata(reg_rdata), .byte_req(byte_req), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .pwr_down(pwr_down), .conv_run(conv_run),
    .cont_read(cont_read), .data_read(data_read), .filt_restart(filt_restart), .cfg_reset(cfg_reset),
    .reset_busy(reset_busy), .cmd_busy(cmd_busy));
  adsc_spi_host i_host (.clk(clk), .miso(miso), .cs_n(cs_n), .sclk(sclk), .din(din));
  // One frame holding the first nb bits of c
  task frame(input [7:0] c, input integer nb);
  begin
    i_host.sel(1'b1);
    i_host.xfer(c, nb, rx);
    i_host.sel(1'b0);
  end
  endtask
  // Register frame; reads send zero bytes so nothing is decoded as a command
  task reg_frame(input [2:0] pfx, input [4:0] ad, input [4:0] cnt, input rd);
    integer j;
  begin
    i_host.sel(1'b1);
    i_host.xfer({pfx, ad}, 8, rx);
    if (rd) `CHK("first", tx_byte, rx)
    i_host.xfer({3'h0, cnt}, 8, rx);
    for (j = 0; j <= cnt; j = j + 1)
    begin
      i_host.xfer(rd ? 8'h00 : wd[j], 8, rx);
      if (rd) `CHK("rdata", rd_key ^ {3'h0, ad + j[4:0]}, rx)
    end
    i_host.sel(1'b0);
  end
  endtask
  task complete_run;
  begin
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // Hang guard, about seven times the tests' own length of some 7000 clk
  initial
  begin
    #1000000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("cont", 1'b1, cont_read)
    `CHK("oe", 1'b0, dout_oe)
    frame(8'h08, 8);
    `CHK("run", 1'b1, conv_run)
    frame(8'h08, 8);
    `CHK("restarts", 1, n_fr)
    frame(8'h0A, 8);
    `CHK("run", 1'b0, conv_run)
    frame(8'h0A, 8);
    `CHK("run", 1'b0, conv_run)
    frame(8'h04, 8);
    frame(8'h08, 8);
    `CHK("sleep", 1'b1, pwr_down)
    `CHK("run", 1'b0, conv_run)
    frame(8'h02, 8);
    `CHK("sleep", 1'b0, pwr_down)
    frame(8'h11, 8);
    `CHK("cont", 1'b0, cont_read)
    frame(8'h12, 8);
    `CHK("reads", 1, n_dr)
    frame(8'h06, 8);
    `CHK("cfg", 1, n_cfg)
    `CHK("restarts", 2, n_fr)
    `CHK("cont", 1'b1, cont_read)
    for (k = 0; k < 6; k = k + 1)
    begin
      op = $random(seed);
      op[7] = 1'b1;
      frame(op, 8);
      `CHK("cont", 1'b1, cont_read)
      `CHK("run", 1'b0, conv_run)
    end
    `CHK("writes", 0, n_wr)
    $display("test commands done");
    frame(8'h08, 7);
    `CHK("run", 1'b1, conv_run)
    frame(8'h0A, 4);
    `CHK("run", 1'b1, conv_run)
    frame(8'h0A, 8);
    `CHK("run", 1'b0, conv_run)
    frame(8'h11, 8);
    frame(8'h10, 7);
    `CHK("cont", 1'b0, cont_read)
    $display("test partial_bytes done");
    for (k = 0; k < 3; k = k + 1)
    begin
      a = $random(seed);
      n = (k == 0) ? 5'h00 : ($random(seed) & 5'h07);
      for (i = 0; i < 8; i = i + 1)
        wd[i] = $random(seed);
      base = n_wr;
      reg_frame(3'h2, a, n, 1'b0);
      `CHK("wcount", base + n + 1, n_wr)
      for (i = 0; i <= n; i = i + 1)
      begin
        `CHK("waddr", a + i[4:0], wr_a[base + i])
        `CHK("wdata", wd[i], wr_d[base + i])
      end
      a = $random(seed);
      n = (k == 0) ? 5'h1F : ($random(seed) & 5'h03);
      tx_byte = $random(seed);
      rd_key = $random(seed);
      base = n_rd;
      reg_frame(3'h1, a, n, 1'b1);
      `CHK("rcount", base + n + 1, n_rd)
    end
    frame(8'h10, 8);
    base = n_rd;
    reg_frame(3'h1, 5'h03, 5'h01, 1'b0);
    `CHK("rcount", base, n_rd)
    `CHK("oe", 1'b0, dout_oe)
    $display("test register_access done");
    complete_run;
  end
endmodule // adsc_cmd_decoder_tb_top
